// ==== mav_pkg.sv ====
package mav_pkg;
    localparam int unsigned MAV_NUM_INST  = 32;
    localparam int unsigned MAV_DATA_W    = 32;
    localparam int unsigned MAV_ACC_W     = 64;
    localparam int unsigned MAV_IDX_W     = 5;
    localparam logic [31:0] MAV_ZERO32    = 32'h0000_0000;
    localparam logic [31:0] MAV_ONE32     = 32'h0000_0001;
    localparam logic [63:0] MAV_ZERO64    = 64'h0;
    localparam logic [31:0] MAV_CNT_MAX   = 32'h7fff_ffff;

    // APB register map
    localparam logic [11:0] MAV_OFF_SEL   = 12'h000;
    localparam logic [11:0] MAV_OFF_CTRL  = 12'h004;
    localparam logic [11:0] MAV_OFF_SAMP  = 12'h008;
    localparam logic [11:0] MAV_OFF_WIN   = 12'h00c;
    localparam logic [11:0] MAV_OFF_AVG   = 12'h010;
    localparam logic [11:0] MAV_OFF_CNT   = 12'h014;
    localparam logic [11:0] MAV_OFF_STAT  = 12'h018;

    // CTRL fields
    localparam int unsigned MAV_CTRL_TRIG = 0;
    localparam int unsigned MAV_CTRL_EN   = 1;
    localparam int unsigned MAV_CTRL_CLR  = 2;
    localparam int unsigned MAV_CTRL_CONT = 3;
    localparam int unsigned MAV_CTRL_ENEV = 4;
    localparam int unsigned MAV_CTRL_W    = 5;
    // STAT fields
    localparam int unsigned MAV_STAT_DONE = 0;
    localparam int unsigned MAV_STAT_RERR = 1;

    typedef struct packed {
        logic trig;
        logic en;
        logic clr;
        logic cont;
        logic enev;
    } mav_ctrl_s;

    typedef struct packed {
        logic signed [31:0] avg;
        logic        [31:0] cnt;
        logic               done;
        logic               rerr;
    } mav_state_s;
endpackage : mav_pkg

// ==== mav_averager.sv ====
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Thirty-two independent averager instances, each with private state.
// - Each trigger rising edge captures the sample into the average.
// - One-time mode: at window count stop, ignore triggers, set done.
// - One-time mode result within one half of the exact mean.
// - Continuous mode keeps a moving window after the count is reached.
// - Continuous mode approximates without storing window samples.
// - Continuous mode also sets done at the count and keeps it set.
// - Before the count, output shows the running average so far.
// - Sample count output reports samples used in the average.
// - With enable evaluation set, operate only while enable is high.
// - Clear high forces count, average and done to zero.
// - Sample and average are full-range 32-bit signed integers.
// - With enable evaluation clear, the enable input is ignored.
// - Default mode after configuration is one-time mode.
// - Range error set when the window count is out of range (negative).
module mav_averager
    import mav_pkg::*;
#(
    parameter int unsigned NUM_INST = MAV_NUM_INST
) (
    input  wire logic        clock,
    input  wire logic        reset,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr
);
    localparam int unsigned IW = $clog2(NUM_INST);

    // Instance select and per-instance registers
    logic [IW-1:0]      sel_r;
    mav_ctrl_s          ctrl_r   [NUM_INST];
    logic signed [31:0] samp_r   [NUM_INST];
    logic        [31:0] win_r    [NUM_INST];
    mav_state_s         st_r     [NUM_INST];
    logic               trig_q_r [NUM_INST];
    logic signed [63:0] sum_r    [NUM_INST];

    // Bus decode
    logic               wr_acc;
    logic               wr_sel_w;
    logic               rd_ok;
    logic        [31:0] rd_nxt;

    // Zero wait states: every access completes at once
    assign wr_acc   = psel & penable & pwrite;
    assign wr_sel_w = wr_acc && (paddr == MAV_OFF_SEL);
    assign pready   = 1'b1;

    // Offsets that decode to a register
    function automatic logic known_off(input logic [11:0] a);
        known_off = (a == MAV_OFF_SEL) || (a == MAV_OFF_CTRL)
                 || (a == MAV_OFF_SAMP) || (a == MAV_OFF_WIN)
                 || (a == MAV_OFF_AVG) || (a == MAV_OFF_CNT)
                 || (a == MAV_OFF_STAT);
    endfunction : known_off

    // Byte-strobe merge into the old word
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        merge = r;
    endfunction : merge

    // Control fields at their register bit positions
    function automatic logic [31:0] pack_ctrl(input mav_ctrl_s c);
        logic [31:0] r;
        r                = MAV_ZERO32;
        r[MAV_CTRL_TRIG] = c.trig;
        r[MAV_CTRL_EN]   = c.en;
        r[MAV_CTRL_CLR]  = c.clr;
        r[MAV_CTRL_CONT] = c.cont;
        r[MAV_CTRL_ENEV] = c.enev;
        pack_ctrl        = r;
    endfunction : pack_ctrl

    // Status flags at their register bit positions
    function automatic logic [31:0] stat_word(input mav_state_s s);
        logic [31:0] r;
        r                = MAV_ZERO32;
        r[MAV_STAT_DONE] = s.done;
        r[MAV_STAT_RERR] = s.rerr;
        stat_word        = r;
    endfunction : stat_word

    // Rounded division, ties away from zero: error at most one half
    function automatic logic signed [63:0] rdiv(input logic signed [63:0] n,
                                                input logic signed [63:0] d);
        logic signed [63:0] h;
        logic signed [63:0] q;
        h = d >>> 1;
        if (n < 0) begin
            q = (n - h) / d;
        end else begin
            q = (n + h) / d;
        end
        rdiv = q;
    endfunction : rdiv

    assign rd_ok   = known_off(paddr);
    assign pslverr = psel & penable & ~rd_ok;

    always_ff @(posedge clock) begin
        if (reset) begin
            sel_r <= '0;
        end else if (wr_sel_w) begin
            sel_r <= pwdata[IW-1:0];
        end
    end

    // Read word for the register addressed in the setup cycle
    always_comb begin
        rd_nxt = MAV_ZERO32;
        unique case (paddr)
            MAV_OFF_SEL:  rd_nxt = {{(32-IW){1'b0}}, sel_r};
            MAV_OFF_CTRL: rd_nxt = pack_ctrl(ctrl_r[sel_r]);
            MAV_OFF_SAMP: rd_nxt = samp_r[sel_r];
            MAV_OFF_WIN:  rd_nxt = win_r[sel_r];
            MAV_OFF_AVG:  rd_nxt = st_r[sel_r].avg;
            MAV_OFF_CNT:  rd_nxt = st_r[sel_r].cnt;
            MAV_OFF_STAT: rd_nxt = stat_word(st_r[sel_r]);
            default:      rd_nxt = MAV_ZERO32;
        endcase
    end

    // Loaded in the setup cycle, held until the next one
    always_ff @(posedge clock) begin
        if (reset) begin
            prdata <= MAV_ZERO32;
        end else if (psel && !penable) begin
            prdata <= rd_nxt;
        end
    end

    for (genvar g = 0; g < NUM_INST; g++) begin : g_inst
        // Per-instance decode
        logic               sel_me;
        logic               edge_w;
        logic               run_w;
        logic               wr_ctrl_w;
        logic               wr_samp_w;
        logic               wr_win_w;
        logic               win_ok_w;
        logic               take_w;
        logic               fill_w;
        logic               slide_w;
        logic               cnt_sat_w;
        // Per-instance arithmetic
        logic        [31:0] ctrl_wv;
        logic        [31:0] cnt_inc_w;
        logic signed [63:0] n64_w;
        logic signed [63:0] s64_w;
        logic signed [63:0] a64_w;
        logic signed [63:0] sum_nxt_w;
        logic signed [31:0] avg_fill_w;
        logic signed [31:0] avg_slide_w;

        // Register writes aimed at this instance
        assign sel_me    = wr_acc && (sel_r == IW'(g));
        assign wr_ctrl_w = sel_me && (paddr == MAV_OFF_CTRL);
        assign wr_samp_w = sel_me && (paddr == MAV_OFF_SAMP);
        assign wr_win_w  = sel_me && (paddr == MAV_OFF_WIN);
        assign ctrl_wv   = merge(pack_ctrl(ctrl_r[g]), pwdata, pstrb);
        assign edge_w    = ctrl_r[g].trig & ~trig_q_r[g];
        assign run_w     = ~ctrl_r[g].enev | ctrl_r[g].en;

        // Which update a trigger edge makes
        assign win_ok_w  = !win_r[g][MAV_DATA_W-1]
                        && (win_r[g] != MAV_ZERO32);
        assign take_w    = run_w && edge_w && win_ok_w
                        && !ctrl_r[g].clr;
        assign fill_w    = take_w && (st_r[g].cnt < win_r[g]);
        assign slide_w   = take_w && !fill_w && ctrl_r[g].cont;
        assign cnt_sat_w = (st_r[g].cnt == MAV_CNT_MAX);

        // Exact sum while filling, exponential step afterwards
        assign n64_w     = $signed({MAV_ZERO32, win_r[g]});
        assign s64_w     = 64'(samp_r[g]);
        assign a64_w     = 64'(st_r[g].avg);
        assign cnt_inc_w = st_r[g].cnt + MAV_ONE32;
        assign sum_nxt_w = sum_r[g] + s64_w;
        assign avg_fill_w  = 32'(rdiv(sum_nxt_w,
                                 $signed({MAV_ZERO32, cnt_inc_w})));
        assign avg_slide_w = 32'(a64_w + rdiv(s64_w - a64_w, n64_w));

        // Control word of this instance
        always_ff @(posedge clock) begin
            if (reset) begin
                ctrl_r[g] <= '0;
            end else if (wr_ctrl_w) begin
                ctrl_r[g].trig <= ctrl_wv[MAV_CTRL_TRIG];
                ctrl_r[g].en   <= ctrl_wv[MAV_CTRL_EN];
                ctrl_r[g].clr  <= ctrl_wv[MAV_CTRL_CLR];
                ctrl_r[g].cont <= ctrl_wv[MAV_CTRL_CONT];
                ctrl_r[g].enev <= ctrl_wv[MAV_CTRL_ENEV];
            end
        end

        always_ff @(posedge clock) begin
            if (reset) begin
                samp_r[g] <= MAV_ZERO32;
            end else if (wr_samp_w) begin
                samp_r[g] <= merge(samp_r[g], pwdata, pstrb);
            end
        end

        always_ff @(posedge clock) begin
            if (reset) begin
                win_r[g] <= MAV_ZERO32;
            end else if (wr_win_w) begin
                win_r[g] <= merge(win_r[g], pwdata, pstrb);
            end
        end

        // Previous trigger level for edge detection
        always_ff @(posedge clock) begin
            if (reset) begin
                trig_q_r[g] <= 1'b0;
            end else begin
                trig_q_r[g] <= ctrl_r[g].trig;
            end
        end

        // Negative window count is out of range
        always_ff @(posedge clock) begin
            if (reset) begin
                st_r[g].rerr <= 1'b0;
            end else begin
                st_r[g].rerr <= win_r[g][MAV_DATA_W-1];
            end
        end

        // Running sum for the exact fill phase
        always_ff @(posedge clock) begin
            if (reset || ctrl_r[g].clr) begin
                sum_r[g] <= MAV_ZERO64;
            end else if (fill_w) begin
                sum_r[g] <= sum_nxt_w;
            end
        end

        // Cumulative mean, then a step with no sample history
        always_ff @(posedge clock) begin
            if (reset || ctrl_r[g].clr) begin
                st_r[g].avg <= MAV_ZERO32;
            end else if (fill_w) begin
                st_r[g].avg <= avg_fill_w;
            end else if (slide_w) begin
                st_r[g].avg <= avg_slide_w;
            end
        end

        // Samples used, saturating at the top of the signed range
        always_ff @(posedge clock) begin
            if (reset || ctrl_r[g].clr) begin
                st_r[g].cnt <= MAV_ZERO32;
            end else if (fill_w) begin
                st_r[g].cnt <= cnt_inc_w;
            end else if (slide_w && !cnt_sat_w) begin
                st_r[g].cnt <= cnt_inc_w;
            end
        end

        // Done stays set until clear; one-time mode holds
        always_ff @(posedge clock) begin
            if (reset || ctrl_r[g].clr) begin
                st_r[g].done <= 1'b0;
            end else if (fill_w && cnt_inc_w == win_r[g]) begin
                st_r[g].done <= 1'b1;
            end else if (slide_w) begin
                st_r[g].done <= 1'b1;
            end
        end
    end
endmodule : mav_averager
`default_nettype wire

// ==== mav_averager_chk.sv ====
`timescale 1ns/1ps
`default_nettype none
module mav_chk
    import mav_pkg::*;
(
    input wire logic        clock,
    input wire logic        reset,
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    wire acc = psel & penable;
    wire rdc = acc & ~pwrite;
    wire bad = paddr > MAV_OFF_STAT;
    a_ready_high:
        assert property (acc |-> pready) else $error("pready low");
    a_err_unmap:
        assert property (acc && bad |-> pslverr) else $error("no pslverr");
    a_err_map:
        assert property (acc && !bad && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("stray pslverr");
    a_rd_unmap:
        assert property (rdc && bad |-> prdata == MAV_ZERO32)
        else $error("unmapped read not zero");
    a_rd_hold:
        assert property (rdc ##1 !psel |-> $stable(prdata))
        else $error("prdata moved");
    a_cnt_range:
        assert property (rdc && paddr == MAV_OFF_CNT |-> !prdata[31])
        else $error("count negative");
    a_stat_bits:
        assert property (rdc && paddr == MAV_OFF_STAT |-> prdata[31:2] == 30'h0)
        else $error("status spare bits");
    a_sel_bits:
        assert property (rdc && paddr == MAV_OFF_SEL |-> prdata[31:5] == 27'h0)
        else $error("select spare bits");
    c_unmap: cover property (acc && bad);
    c_done: cover property (rdc && paddr == MAV_OFF_STAT && prdata[0]);
    c_rerr: cover property (rdc && paddr == MAV_OFF_STAT && prdata[1]);
endmodule : mav_chk
bind mav_averager mav_chk chk_u (.clock, .reset, .paddr, .psel, .penable,
    .pwrite, .prdata, .pready, .pslverr);
`default_nettype wire

// ==== mav_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// APB host: setup cycle, then access until pready
module mav_host (
    input  wire logic        clock,
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr,
    output logic      [11:0] paddr = 12'h000,
    output logic             psel = 1'b0,
    output logic             penable = 1'b0,
    output logic             pwrite = 1'b0,
    output logic      [31:0] pwdata = 32'h0,
    output logic      [3:0]  pstrb = 4'hf
);
    logic [31:0] rdata;
    logic        rerr;
    logic [3:0]  strb_q = 4'hf;
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d);
        @(posedge clock);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        pstrb   <= strb_q;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rdata = prdata;
        rerr  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        pwdata  <= ~d;
    endtask : xfer
endmodule : mav_host
`default_nettype wire

// ==== test_moving_average_block.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin \
    num_checks++; \
    if ((a) !== (b)) begin \
        err_total++; \
        $display("Error %0t: got %h want %h", $time, a, b); \
    end \
end
module test_moving_average_block
    import mav_pkg::*;
;
    logic        clock = 1'b0;
    logic        reset = 1'b1;
    int          err_total = 0;
    int          num_checks = 0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb;
    logic        psel, penable, pwrite, pready, pslverr;
    always #50 clock = ~clock;
    mav_host host_u (.clock, .prdata, .pready, .pslverr, .paddr, .psel,
        .penable, .pwrite, .pwdata, .pstrb);
    mav_averager dut_u (.clock, .reset, .paddr, .psel, .penable, .pwrite,
        .pwdata, .pstrb, .prdata, .pready, .pslverr);
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        host_u.xfer(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        host_u.xfer(1'b0, a, 32'h0);
        `CHK(host_u.rdata, e)
    endtask : rd
    // Load sample, then raise trigger from low
    task automatic smp(input logic [31:0] c, input logic [31:0] x);
        wr(MAV_OFF_SAMP, x);
        wr(MAV_OFF_CTRL, c);
        wr(MAV_OFF_CTRL, c | 32'h1);
        repeat (2) @(posedge clock);
    endtask : smp
    task automatic st(input logic [31:0] a, input logic [31:0] n,
                      input logic [31:0] s);
        rd(MAV_OFF_AVG, a);
        rd(MAV_OFF_CNT, n);
        rd(MAV_OFF_STAT, s);
    endtask : st
    task automatic final_report();
        $display("Checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : final_report
    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'b0;
        st(32'h0, 32'h0, 32'h0);
        rd(MAV_OFF_CTRL, 32'h0);
        wr(MAV_OFF_SEL, 32'h1);
        wr(MAV_OFF_WIN, 32'h3);
        smp(32'h0, 32'ha);
        st(32'ha, 32'h1, 32'h0);
        smp(32'h0, 32'h14);
        st(32'hf, 32'h2, 32'h0);
        smp(32'h0, 32'h1f);
        st(32'h14, 32'h3, 32'h1);
        smp(32'h0, 32'h3e8);
        st(32'h14, 32'h3, 32'h1);
        wr(MAV_OFF_SEL, 32'h0);
        st(32'h0, 32'h0, 32'h0);
        wr(MAV_OFF_SEL, 32'h1);
        smp(32'h4, 32'h9);
        st(32'h0, 32'h0, 32'h0);
        wr(MAV_OFF_WIN, 32'h2);
        smp(32'h8, 32'h4);
        smp(32'h8, 32'h8);
        st(32'h6, 32'h2, 32'h1);
        smp(32'h8, 32'h10);
        st(32'hb, 32'h3, 32'h1);
        wr(MAV_OFF_CTRL, 32'h4);
        smp(32'h10, 32'h7);
        st(32'h0, 32'h0, 32'h0);
        smp(32'h12, 32'h7);
        st(32'h7, 32'h1, 32'h0);
        smp(32'h0, 32'h9);
        st(32'h8, 32'h2, 32'h1);
        wr(MAV_OFF_CTRL, 32'h4);
        wr(MAV_OFF_WIN, 32'h1);
        smp(32'h0, 32'h8000_0000);
        st(32'h8000_0000, 32'h1, 32'h1);
        wr(MAV_OFF_WIN, 32'hffff_fffb);
        repeat (2) @(posedge clock);
        rd(MAV_OFF_STAT, 32'h3);
        rd(12'h01c, 32'h0);
        `CHK(host_u.rerr, 1'b1)
        wr(MAV_OFF_SEL, 32'h2);
        host_u.strb_q = 4'h1;
        wr(MAV_OFF_WIN, 32'hffff_ff05);
        host_u.strb_q = 4'hf;
        rd(MAV_OFF_WIN, 32'h5);
        final_report();
    end
    initial begin
        repeat (8000) @(posedge clock);
        err_total++;
        final_report();
    end
endmodule : test_moving_average_block
`default_nettype wire
